//--- design/card_config_tuple_decoder.sv
`timescale 1ns/1ps

module card_config_tuple_decoder
    import tuple_decoder_pkg::*;
(
    input  wire logic              aclk,     // Bus clock
    input  wire logic              aresetn,  // Synchronous reset, active low
    input  wire tuple_byte_s       tuple_in, // Structure bytes from storage
    input  wire logic [ADDR_W-1:0] awaddr,   // Write address
    input  wire logic              awvalid,  // Write address valid
    output logic                   awready,  // Write address ready
    input  wire logic [31:0]       wdata,    // Write data
    input  wire logic [3:0]        wstrb,    // Write byte enables
    input  wire logic              wvalid,   // Write data valid
    output logic                   wready,   // Write data ready
    output logic [1:0]             bresp,    // Write response
    output logic                   bvalid,   // Write response valid
    input  wire logic              bready,   // Write response ready
    input  wire logic [ADDR_W-1:0] araddr,   // Read address
    input  wire logic              arvalid,  // Read address valid
    output logic                   arready,  // Read address ready
    output logic [31:0]            rdata,    // Read data
    output logic [1:0]             rresp,    // Read response
    output logic                   rvalid,   // Read data valid
    input  wire logic              rready    // Read data ready
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        walk_e               walk;
        kind_e               kind;
        logic [7:0]          idx;
        logic [7:0]          link;
        logic [1:0]          id_len;
        logic [3:0]          str_count;
        logic [31:0]         iface_id;
        logic [7:0]          last_index;
        logic [31:0]         status_ptr;
        logic [7:0]          method;
        logic [7:0]          save_restore_duration;
        logic [2:0]          cif_count;
        logic [1:0]          pwr_count;
        logic [STATUS_W-1:0] status;
        logic [3:0]          ctrl;
        logic                awready;
        logic                wready;
        logic                aw_held;
        logic                w_held;
        logic [ADDR_W-1:0]   waddr;
        logic [31:0]         wdata;
        logic [3:0]          wstrb;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [1:0]          rresp;
        logic [31:0]         rdata;
    } state_s;

    localparam state_s STATE_RST = '0;

    state_s s_ff;
    state_s nxt_s;

    // ------------------------------------------------------------------
    // Register read decode
    // ------------------------------------------------------------------
    function automatic logic [33:0] read_reg(input state_s s, input logic [ADDR_W-1:0] a);
        logic [31:0] d;
        logic [1:0]  r;
        d = 32'h0;
        r = RESP_OKAY;
        case (a)
            REG_CTRL:     d[3:0] = s.ctrl;
            REG_CMD:      d = 32'h0;
            REG_STATUS:   d[STATUS_W-1:0] = s.status;
            REG_IFACE_ID: d = s.iface_id;
            REG_IFACE:    d[10:0] = {s.cif_count, s.str_count, s.id_len, 2'h0};
            REG_CB_LAST:  d[10:0] = {s.status_ptr[SEL_W-1:0], s.last_index};
            REG_PTR_RAW:  d = s.status_ptr;
            // Selector bits count as zero within the offset
            REG_PTR_OFS:  d = {s.status_ptr[31:SEL_W], {SEL_W{1'b0}}};
            // Bit 16 tells the host to move state through the buffer
            REG_PWR:      d[16:0] = {s.method != METHOD_NV, s.save_restore_duration, s.method};
            REG_PWR_MS:   d[15:0] = 16'(s.save_restore_duration) * 16'(PWR_UNIT_MS);
            default:      r = RESP_SLVERR;
        endcase
        return {r, d};
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [STATUS_W-1:0] set;
        logic [STATUS_W-1:0] clr;
        logic [7:0]          b;
        logic [31:0]         ptr;
        logic [1:0]          slot;
        logic                last_byte;
        logic [33:0]         rd;
        set       = '0;
        clr       = '0;
        b         = tuple_in.data;
        ptr       = s_ff.status_ptr;
        slot      = 2'h0;
        last_byte = 1'b0;
        rd        = 34'h0;
        nxt_s     = s_ff;

        // --------------------------------------------------------------
        // Tuple walker
        // --------------------------------------------------------------
        if (tuple_in.valid && s_ff.ctrl[CTRL_ENABLE]) begin
            if (tuple_in.start) begin
                nxt_s.idx       = IDX_LINK;
                nxt_s.walk      = W_BODY;
                nxt_s.str_count = 4'h0;
                case (b)
                    CODE_CIF: begin
                        nxt_s.kind     = K_CIF;
                        nxt_s.iface_id = 32'h0;
                        nxt_s.id_len   = 2'h0;
                        if (s_ff.cif_count == MAX_CIF) begin
                            set[ST_MANY_CIF] = 1'b1;
                        end else begin
                            nxt_s.cif_count = s_ff.cif_count + 3'h1;
                        end
                    end
                    CODE_CB: begin
                        nxt_s.kind       = K_CB;
                        nxt_s.cif_count  = 3'h0;
                        nxt_s.status_ptr = 32'h0;
                    end
                    CODE_PWR: begin
                        nxt_s.kind = K_PWR;
                        if (s_ff.pwr_count != 2'h0) begin
                            set[ST_DUP_PWR] = 1'b1;
                        end
                        if (s_ff.ctrl[CTRL_MULTI] && s_ff.ctrl[CTRL_GLOBAL]) begin
                            set[ST_GLB_PWR] = 1'b1;
                        end
                        if (s_ff.pwr_count != 2'h3) begin
                            nxt_s.pwr_count = s_ff.pwr_count + 2'h1;
                        end
                    end
                    default: begin
                        nxt_s.kind = K_NONE;
                        nxt_s.walk = W_IDLE;
                    end
                endcase
            end else if (s_ff.walk == W_BODY) begin
                nxt_s.idx = s_ff.idx + 8'h1;
                last_byte = ({1'b0, s_ff.idx} == {1'b0, s_ff.link} + 9'h1);
                if (s_ff.idx == IDX_LINK) begin
                    nxt_s.link = b;
                    last_byte  = (b == 8'h0);
                    // A CIF, CB or save/restore link too short for its tuple kind
                    if ((s_ff.kind == K_CIF && b < MIN_LINK_CIF) ||
                        (s_ff.kind == K_CB && b < MIN_LINK_CB) ||
                        (s_ff.kind == K_PWR && b < MIN_LINK_PWR_NV)) begin
                        set[ST_SHORT] = 1'b1;
                    end
                end else begin
                    case (s_ff.kind)
                        K_CIF: begin
                            if (s_ff.idx == IDX_FIRST) begin
                                nxt_s.iface_id = {24'h0, b};
                                nxt_s.id_len   = b[7:6];
                            end else if (s_ff.idx <= IDX_FIRST + {6'h0, s_ff.id_len}) begin
                                slot = s_ff.idx[1:0] + 2'h2;
                                nxt_s.iface_id[{slot, 3'h0} +: 8] = b;
                            end else if (b == BYTE_END) begin
                                last_byte = 1'b1;
                            end else if (b == BYTE_ZERO && s_ff.str_count != 4'hf) begin
                                nxt_s.str_count = s_ff.str_count + 4'h1;
                            end
                            if (last_byte) begin
                                set[ST_CIF_DONE] = 1'b1;
                            end
                        end
                        K_CB: begin
                            if (s_ff.idx == IDX_FIRST && b != CB_FIELD_SIZE) begin
                                set[ST_NONZERO] = 1'b1;
                            end
                            if (s_ff.idx == IDX_LAST) begin
                                nxt_s.last_index = b;
                                if (b[7:6] != 2'h0) begin
                                    set[ST_NONZERO] = 1'b1;
                                end
                            end
                            if (s_ff.idx >= IDX_PTR_LO && s_ff.idx <= IDX_PTR_HI) begin
                                slot = s_ff.idx[1:0];
                                ptr[{slot, 3'h0} +: 8] = b;
                                nxt_s.status_ptr = ptr;
                            end
                            if (s_ff.idx == IDX_PTR_HI) begin
                                set[ST_CB_DONE] = 1'b1;
                                // Only selectors 1-6 are legal memory spaces
                                if (ptr[SEL_W-1:0] == SEL_RSVD) begin
                                    set[ST_RSVD] = 1'b1;
                                end
                                if (ptr[SEL_W-1:0] == SEL_NONE && ptr[31:SEL_W] != '0) begin
                                    set[ST_NONZERO] = 1'b1;
                                end
                            end
                            // Subtuple area past the pointer is skipped unread
                        end
                        K_PWR: begin
                            if (s_ff.idx == IDX_FIRST) begin
                                nxt_s.method = b;
                                if (b != METHOD_ATTR && b != METHOD_COMMON &&
                                    b != METHOD_NV) begin
                                    set[ST_RSVD] = 1'b1;
                                end
                                if (s_ff.link < ((b == METHOD_NV) ? MIN_LINK_PWR_NV
                                                                  : MIN_LINK_PWR_BUF)) begin
                                    set[ST_SHORT] = 1'b1;
                                end
                            end
                            if (s_ff.idx == IDX_TIME) begin
                                nxt_s.save_restore_duration   = b;
                                set[ST_PWR_DONE] = 1'b1;
                            end
                        end
                        default: begin
                            last_byte = 1'b1;
                        end
                    endcase
                end
                if (last_byte) begin
                    nxt_s.walk = W_IDLE;
                end
            end
        end

        // --------------------------------------------------------------
        // Write channel: address and data taken in either order
        // --------------------------------------------------------------
        if (awvalid && s_ff.awready) begin
            nxt_s.aw_held = 1'b1;
            nxt_s.waddr   = awaddr;
        end
        if (wvalid && s_ff.wready) begin
            nxt_s.w_held = 1'b1;
            nxt_s.wdata  = wdata;
            nxt_s.wstrb  = wstrb;
        end
        if (s_ff.bvalid && bready) begin
            nxt_s.bvalid = 1'b0;
        end
        if (s_ff.aw_held && s_ff.w_held && !s_ff.bvalid) begin
            nxt_s.aw_held = 1'b0;
            nxt_s.w_held  = 1'b0;
            nxt_s.bvalid  = 1'b1;
            nxt_s.bresp   = RESP_OKAY;
            case (s_ff.waddr)
                REG_CTRL: begin
                    if (s_ff.wstrb[0]) begin
                        nxt_s.ctrl = s_ff.wdata[3:0];
                    end
                end
                REG_CMD: begin
                    if (s_ff.wstrb[0] && s_ff.wdata[CMD_BEGIN]) begin
                        nxt_s.pwr_count = 2'h0;
                        nxt_s.cif_count = 3'h0;
                    end
                    if (s_ff.wstrb[0] && s_ff.wdata[CMD_END] && s_ff.ctrl[CTRL_MULTI] &&
                        s_ff.ctrl[CTRL_PMREG] && s_ff.pwr_count == 2'h0) begin
                        set[ST_NO_PWR] = 1'b1;
                    end
                end
                REG_STATUS: begin
                    if (s_ff.wstrb[0]) begin
                        clr[7:0] = s_ff.wdata[7:0];
                    end
                    if (s_ff.wstrb[1]) begin
                        clr[STATUS_W-1:8] = s_ff.wdata[STATUS_W-1:8];
                    end
                end
                REG_IFACE_ID, REG_IFACE, REG_CB_LAST, REG_PTR_RAW,
                REG_PTR_OFS, REG_PWR, REG_PWR_MS: begin
                    nxt_s.bresp = RESP_OKAY;
                end
                default: begin
                    nxt_s.bresp = RESP_SLVERR;
                end
            endcase
        end
        nxt_s.awready = !nxt_s.aw_held && !nxt_s.bvalid;
        nxt_s.wready  = !nxt_s.w_held && !nxt_s.bvalid;

        // Event set wins over a clear in the same cycle
        nxt_s.status = (s_ff.status & ~clr) | set;

        // --------------------------------------------------------------
        // Read channel
        // --------------------------------------------------------------
        if (s_ff.rvalid && rready) begin
            nxt_s.rvalid = 1'b0;
        end
        if (arvalid && s_ff.arready) begin
            rd           = read_reg(s_ff, araddr);
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp  = rd[33:32];
            nxt_s.rdata  = rd[31:0];
        end
        nxt_s.arready = !nxt_s.rvalid;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= STATE_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign awready = s_ff.awready;
    assign wready  = s_ff.wready;
    assign bvalid  = s_ff.bvalid;
    assign bresp   = s_ff.bresp;
    assign arready = s_ff.arready;
    assign rvalid  = s_ff.rvalid;
    assign rresp   = s_ff.rresp;
    assign rdata   = s_ff.rdata;

endmodule // card_config_tuple_decoder

//--- design/tuple_decoder_pkg.sv
package tuple_decoder_pkg;

    // ------------------------------------------------------------------
    // Tuple codes and byte markers
    // ------------------------------------------------------------------
    localparam logic [7:0] CODE_CIF         = 8'hc0;
    localparam logic [7:0] CODE_CB          = 8'h04;
    localparam logic [7:0] CODE_PWR         = 8'h08;
    localparam logic [7:0] BYTE_END         = 8'hff;
    localparam logic [7:0] BYTE_ZERO        = 8'h00;
    localparam logic [7:0] MIN_LINK_CIF     = 8'h01;
    localparam logic [7:0] MIN_LINK_CB      = 8'h06;
    localparam logic [7:0] MIN_LINK_PWR_NV  = 8'h06;
    localparam logic [7:0] MIN_LINK_PWR_BUF = 8'h0e;
    localparam logic [7:0] CB_FIELD_SIZE    = 8'h03;
    localparam logic [7:0] METHOD_ATTR      = 8'h00;
    localparam logic [7:0] METHOD_COMMON    = 8'h01;
    localparam logic [7:0] METHOD_NV        = 8'h80;

    // ------------------------------------------------------------------
    // Byte positions within a tuple
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_LINK   = 8'h01;
    localparam logic [7:0] IDX_FIRST  = 8'h02;
    localparam logic [7:0] IDX_LAST   = 8'h03;
    localparam logic [7:0] IDX_PTR_LO = 8'h04;
    localparam logic [7:0] IDX_PTR_HI = 8'h07;
    localparam logic [7:0] IDX_TIME   = 8'h03;
    localparam logic [2:0] SEL_NONE   = 3'h0;
    localparam logic [2:0] SEL_RSVD   = 3'h7;
    localparam int         SEL_W      = 3;
    localparam logic [2:0] MAX_CIF    = 3'h4;
    localparam int         PWR_UNIT_MS = 4;

    // ------------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------------
    localparam int         ADDR_W       = 8;
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_CMD      = 8'h04;
    localparam logic [7:0] REG_STATUS   = 8'h08;
    localparam logic [7:0] REG_IFACE_ID = 8'h0c;
    localparam logic [7:0] REG_IFACE    = 8'h10;
    localparam logic [7:0] REG_CB_LAST  = 8'h14;
    localparam logic [7:0] REG_PTR_RAW  = 8'h18;
    localparam logic [7:0] REG_PTR_OFS  = 8'h1c;
    localparam logic [7:0] REG_PWR      = 8'h20;
    localparam logic [7:0] REG_PWR_MS   = 8'h24;
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_MULTI  = 1;
    localparam int CTRL_GLOBAL = 2;
    localparam int CTRL_PMREG  = 3;
    localparam int CMD_BEGIN   = 0;
    localparam int CMD_END     = 1;
    localparam int ST_SHORT    = 0;
    localparam int ST_NONZERO  = 1;
    localparam int ST_RSVD     = 2;
    localparam int ST_DUP_PWR  = 3;
    localparam int ST_GLB_PWR  = 4;
    localparam int ST_MANY_CIF = 5;
    localparam int ST_NO_PWR   = 6;
    localparam int ST_CIF_DONE = 7;
    localparam int ST_CB_DONE  = 8;
    localparam int ST_PWR_DONE = 9;
    localparam int STATUS_W    = 10;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {W_IDLE, W_BODY} walk_e;
    typedef enum logic [1:0] {K_NONE, K_CIF, K_CB, K_PWR} kind_e;

    typedef struct packed {
        logic       start;
        logic       valid;
        logic [7:0] data;
    } tuple_byte_s;

endpackage

//--- testbench/card_config_tuple_decoder_sva.sv
`timescale 1ns/1ps
module tuple_decoder_sva
    import tuple_decoder_pkg::*;
(
    input logic        aclk,    // Bus clock
    input logic        aresetn, // Reset, active low
    input logic        awvalid, // Write address valid
    input logic        awready, // Write address ready
    input logic        wvalid,  // Write data valid
    input logic        wready,  // Write data ready
    input logic        bvalid,  // Write response valid
    input logic        bready,  // Write response ready
    input logic        arvalid, // Read address valid
    input logic        arready, // Read address ready
    input logic [31:0] rdata,   // Read data
    input logic [1:0]  rresp,   // Read response
    input logic        rvalid,  // Read data valid
    input logic        rready   // Read data ready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence b_done_s; bvalid && bready; endsequence
    sequence reopen_s; !bvalid && awready && wready; endsequence
    write_answer_a: assert property ((awvalid && awready && wvalid && wready) |-> ##2 bvalid)
        else $error("write response missing");
    read_answer_a: assert property ((arvalid && arready) |=> rvalid)
        else $error("read data missing");
    one_read_a: assert property (rvalid |-> !arready)
        else $error("read address open while data pending");
    one_write_a: assert property (bvalid |-> !(awready || wready))
        else $error("write channels open while response pending");
    write_reopen_a: assert property (b_done_s |=> reopen_s)
        else $error("write channels did not reopen");
    read_close_a: assert property ((rvalid && rready) |=> (!rvalid && arready))
        else $error("read channel did not close and reopen");
    slverr_zero_a: assert property ((rvalid && rresp == RESP_SLVERR) |-> rdata == 32'h0)
        else $error("error read returned data");
    reset_idle_a: assert property (disable iff (1'b0)
        !aresetn |=> !(bvalid || rvalid || awready || wready || arready))
        else $error("bus outputs active after reset");
endmodule // tuple_decoder_sva

bind card_config_tuple_decoder tuple_decoder_sva i_sva (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

//--- testbench/tuple_source.sv
`timescale 1ns/1ps
module tuple_source
    import tuple_decoder_pkg::*;
(
    input  logic        aclk,     // Bus clock
    output tuple_byte_s tuple_out // Structure bytes toward the walker
);
    initial tuple_out = '{start: 1'b0, valid: 1'b0, data: 8'h5a};
    // Idle lines carry the inverse so a stale byte never passes for data
    task automatic play(input logic [127:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            tuple_out <= '{start: (i == 0), valid: 1'b1, data: b[8*i +: 8]};
            if (i == 2) begin
                @(posedge aclk);
                tuple_out <= '{start: 1'b0, valid: 1'b0, data: ~b[8*i +: 8]};
            end
        end
        @(posedge aclk);
        tuple_out <= '{start: 1'b0, valid: 1'b0, data: ~tuple_out.data};
    endtask
endmodule // tuple_source

//--- testbench/test_card_config_tuple_decoder.sv
`timescale 1ns/1ps
module test_card_config_tuple_decoder;
    import tuple_decoder_pkg::*;
    typedef struct {logic [127:0] b; int n; logic [7:0] a; logic [31:0] e; logic [31:0] m;} row_s;
    localparam logic [63:0] CB_OK  = 64'h78_56_34_12_05_03_06_04;
    localparam logic [63:0] PWR_NV = 64'h00_00_00_00_14_80_06_08;
    logic              aclk, aresetn;
    tuple_byte_s       tuple_in;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready;
    logic [31:0]       wdata, rdata, got;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp, resp;
    int                n_errors = 0;
    int                num_checks = 0;
    row_s rows[20] = '{
        '{64'hff_00_41_12_34_81_06_c0, 8, REG_IFACE_ID, 32'h00123481, '1},
        '{64'hff_00_41_12_34_81_06_c0, 8, REG_IFACE, 32'h18, 32'hfc},
        '{32'hff_05_02_c0, 4, REG_IFACE_ID, 32'h5, '1},
        '{16'h00_c0, 2, REG_STATUS, 32'h1, 32'h1},
        '{CB_OK, 8, REG_PTR_OFS, 32'h78563410, '1},
        '{CB_OK, 8, REG_PTR_RAW, 32'h78563412, '1},
        '{CB_OK, 8, REG_CB_LAST, 32'h205, 32'h7ff},
        '{CB_OK, 8, REG_STATUS, 32'h100, 32'h107},
        '{80'h00_ff_78_56_34_12_05_03_08_04, 10, REG_STATUS, 32'h100, 32'h107},
        '{56'h56_34_12_05_03_05_04, 7, REG_STATUS, 32'h1, 32'h1},
        '{64'h78_56_34_12_05_43_06_04, 8, REG_STATUS, 32'h2, 32'h2},
        '{64'h78_56_34_12_85_03_06_04, 8, REG_STATUS, 32'h2, 32'h2},
        '{64'h78_56_34_17_05_03_06_04, 8, REG_STATUS, 32'h4, 32'h4},
        '{64'h00_00_01_00_05_03_06_04, 8, REG_STATUS, 32'h2, 32'h2},
        '{PWR_NV, 8, REG_PWR, 32'h1480, 32'h1ffff},
        '{PWR_NV, 8, REG_PWR_MS, 32'h50, '1},
        '{64'h00_00_00_00_14_00_06_08, 8, REG_STATUS, 32'h201, 32'h201},
        '{16'h00_08, 2, REG_STATUS, 32'h1, 32'h201},
        '{128'h01_02_0e_08, 16, REG_STATUS, 32'h204, 32'h204},
        '{128'h01_01_0e_08, 16, REG_PWR, 32'h10101, 32'h1ffff}};
    card_config_tuple_decoder i_dut (.aclk(aclk), .aresetn(aresetn), .tuple_in(tuple_in),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    tuple_source i_src (.aclk(aclk), .tuple_out(tuple_in));
    always #12.5 aclk = ~aclk;
    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit done = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                resp = bresp;
                done = 1;
            end
        end
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        bit done = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                got = rdata;
                resp = rresp;
                done = 1;
            end
        end
        rready <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic fresh(input logic [31:0] ctrl);
        wr(REG_CTRL, ctrl);
        wr(REG_CMD, 32'h1);
        wr(REG_STATUS, 32'h3ff);
    endtask
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (30000) @(posedge aclk);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        i_src.play(CB_OK, 8);
        rd(REG_STATUS);
        chk(got, 32'h0);
        rd(REG_CTRL);
        chk(got, 32'h0);
        rd(8'h40);
        chk({got[29:0], resp}, {30'h0, RESP_SLVERR});
        wr(8'h44, 32'h1);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        $display("reset and map test done");
        foreach (rows[i]) begin
            fresh(32'h1);
            i_src.play(rows[i].b, rows[i].n);
            rd(rows[i].a);
            chk(got & rows[i].m, rows[i].e);
            $display("row %0d done", i);
        end
        fresh(32'h1);
        i_src.play(PWR_NV, 8);
        i_src.play(PWR_NV, 8);
        rd(REG_STATUS);
        chk(got & 32'h8, 32'h8);
        fresh(32'h7);
        i_src.play(PWR_NV, 8);
        rd(REG_STATUS);
        chk(got & 32'h10, 32'h10);
        fresh(32'hb);
        i_src.play(PWR_NV, 8);
        wr(REG_CMD, 32'h2);
        rd(REG_STATUS);
        chk(got & 32'h40, 32'h0);
        fresh(32'hb);
        wr(REG_CMD, 32'h2);
        rd(REG_STATUS);
        chk(got & 32'h40, 32'h40);
        fresh(32'h1);
        repeat (4) i_src.play(32'hff_05_02_c0, 4);
        rd(REG_STATUS);
        chk(got & 32'ha0, 32'h80);
        i_src.play(32'hff_05_02_c0, 4);
        rd(REG_STATUS);
        chk(got & 32'h20, 32'h20);
        $display("structure tests done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(REG_STATUS);
        chk(got, 32'h0);
        rd(REG_CTRL);
        chk(got, 32'h0);
        $display("mid-run reset test done");
        tally_and_finish();
    end
endmodule // test_card_config_tuple_decoder
